// *** common/ifld_pkg.sv ***
// package of constants and types for the integer and float load unit
package ifld_pkg;
  localparam logic [5:0] OP_LDSB  = 6'h09;
  localparam logic [5:0] OP_LDSH  = 6'h0A;
  localparam logic [5:0] OP_LDUB  = 6'h01;
  localparam logic [5:0] OP_LDUH  = 6'h02;
  localparam logic [5:0] OP_LDW   = 6'h00;
  localparam logic [5:0] OP_LDD   = 6'h03;
  localparam logic [5:0] OP_LDSBA = 6'h19;
  localparam logic [5:0] OP_LDSHA = 6'h1A;
  localparam logic [5:0] OP_LDUBA = 6'h11;
  localparam logic [5:0] OP_LDUHA = 6'h12;
  localparam logic [5:0] OP_LDWA  = 6'h10;
  localparam logic [5:0] OP_LDDA  = 6'h13;
  localparam logic [5:0] OP_FLDS  = 6'h20;
  localparam logic [5:0] OP_FLDD  = 6'h23;
  localparam logic [5:0] OP_FLDSR = 6'h21;
  // instruction field positions
  localparam int RD_LSB   = 25;
  localparam int SUBOP_LSB = 19;
  localparam int SRC1_LSB  = 14;
  localparam int IMM_BIT  = 13;
  localparam int ASI_LSB  = 5;
  // fixed space ids for normal loads
  localparam logic [7:0] ASI_USER_DATA = 8'h0A;
  localparam logic [7:0] ASI_SUPV_DATA = 8'h0B;
  localparam logic [2:0] FTT_BAD_REG   = 3'h6;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
  // trap cause codes
  typedef enum logic [2:0] {
    TRAP_NONE   = 3'h0,
    TRAP_PRIV   = 3'h1,
    TRAP_ENC    = 3'h2,
    TRAP_ALIGN  = 3'h3,
    TRAP_FPOFF  = 3'h4,
    TRAP_FPFLT  = 3'h5
  } ifld_trap_t;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_DRAIN = 5'b00010,
    ST_MEM0  = 5'b00100,
    ST_MEM1  = 5'b01000,
    ST_DONE  = 5'b10000
  } ifld_state_t;
endpackage

// *** rtl/ifld_load_unit.sv ***
// load instruction decode and execute unit
`timescale 1ns/100ps
module ifld_load_unit (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               issue_valid,
  input  wire logic [31:0]        instr,
  input  wire logic [31:0]        src_one_value,
  input  wire logic [31:0]        src_two_value,
  input  wire logic               supervisor_bit,
  input  wire logic               fpu_enable_bit,
  input  wire logic               fpu_present,
  input  wire logic               float_operate_busy,
  output logic                    issue_ready,
  output logic                    mem_req,
  output logic                    mem_lock,
  output logic [31:0]             mem_addr,
  output logic [7:0]              mem_space,
  input  wire logic               mem_ack,
  input  wire logic [31:0]        mem_rdata,
  output logic                    int_wr_en,
  output logic [4:0]              int_wr_idx,
  output logic                    fp_wr_en,
  output logic [4:0]              fp_wr_idx,
  output logic                    fsr_wr_en,
  output logic [31:0]             wr_data,
  output logic                    trap_valid,
  output ifld_pkg::ifld_trap_t    trap_cause,
  output logic [2:0]              float_trap_type,
  output logic                    done
);
  import ifld_pkg::*;

  // instruction fields
  wire [5:0]  sub_opcode_field    = instr[SUBOP_LSB +: 6];
  wire [4:0]  dest_reg_field      = instr[RD_LSB +: 5];
  wire        imm_sel             = instr[IMM_BIT];
  wire [7:0]  space_id_field      = instr[ASI_LSB +: 8];
  wire [12:0] signed_offset_field = instr[12:0];

  // opcode class decode
  wire op_sb   = (sub_opcode_field == OP_LDSB) || (sub_opcode_field == OP_LDSBA);
  wire op_sh   = (sub_opcode_field == OP_LDSH) || (sub_opcode_field == OP_LDSHA);
  wire op_ub   = (sub_opcode_field == OP_LDUB) || (sub_opcode_field == OP_LDUBA);
  wire op_uh   = (sub_opcode_field == OP_LDUH) || (sub_opcode_field == OP_LDUHA);
  wire op_w    = (sub_opcode_field == OP_LDW)  || (sub_opcode_field == OP_LDWA);
  wire op_d    = (sub_opcode_field == OP_LDD)  || (sub_opcode_field == OP_LDDA);
  wire op_alt  = (sub_opcode_field == OP_LDSBA) || (sub_opcode_field == OP_LDSHA)
              || (sub_opcode_field == OP_LDUBA) || (sub_opcode_field == OP_LDUHA)
              || (sub_opcode_field == OP_LDWA)  || (sub_opcode_field == OP_LDDA);
  wire op_fs   = sub_opcode_field == OP_FLDS;
  wire op_fd   = sub_opcode_field == OP_FLDD;
  wire op_fsr  = sub_opcode_field == OP_FLDSR;
  wire op_fp   = op_fs | op_fd | op_fsr;
  wire op_any  = op_sb | op_sh | op_ub | op_uh | op_w | op_d | op_fp;
  wire is_dbl  = op_d | op_fd;

  // effective address, reg+reg or reg+offset
  wire [31:0] ofs_ext  = {{19{signed_offset_field[12]}}, signed_offset_field};
  wire [31:0] eff_addr = src_one_value + (imm_sel ? ofs_ext : src_two_value);

  // address space select
  wire [7:0] space_sel = op_alt ? space_id_field
                       : (supervisor_bit ? ASI_SUPV_DATA : ASI_USER_DATA);

  // alignment checks per size; byte loads never misalign
  wire half_bad = (op_sh | op_uh) & eff_addr[0];
  wire word_bad = (op_w | op_fs | op_fsr) & (eff_addr[1:0] != 2'b00);
  wire dbl_bad  = is_dbl & (eff_addr[2:0] != 3'b000);
  wire misalign = half_bad | word_bad | dbl_bad;

  // trap priority: fpu off, privilege, encoding, fpu fault, alignment
  wire fp_off   = op_fp & (~fpu_enable_bit | ~fpu_present);
  wire priv_bad = op_alt & ~supervisor_bit;
  wire enc_bad  = (op_alt & imm_sel) | (op_d & dest_reg_field[0]);
  wire fp_flt   = op_fd & dest_reg_field[0];
  ifld_trap_t trap_sel;
  assign trap_sel = fp_off   ? TRAP_FPOFF
                  : priv_bad ? TRAP_PRIV
                  : enc_bad  ? TRAP_ENC
                  : fp_flt   ? TRAP_FPFLT
                  : misalign ? TRAP_ALIGN
                  : TRAP_NONE;

  // byte and half extraction, big-endian lanes
  function automatic logic [31:0] align_data(input logic [31:0] w, input logic [1:0] a,
                                             input logic sb, input logic sh,
                                             input logic ub, input logic uh);
    logic [7:0]  b;
    logic [15:0] h;
    b = w[8 * (3 - a) +: 8];
    h = a[1] ? w[15:0] : w[31:16];
    if (sb) begin
      align_data = {{24{b[7]}}, b};
    end else if (ub) begin
      align_data = {24'h00_0000, b};
    end else if (sh) begin
      align_data = {{16{h[15]}}, h};
    end else if (uh) begin
      align_data = {16'h0000, h};
    end else begin
      align_data = w;
    end
  endfunction

  ifld_state_t state_reg, state_next;
  logic [31:0] addr_reg;
  logic [7:0]  space_reg;
  logic [4:0]  rd_reg;
  logic [5:0]  kind_reg;
  logic [31:0] data_reg;
  logic        wr_int_reg, wr_fp_reg, wr_fsr_reg;
  logic [4:0]  wr_idx_reg;
  logic        trap_reg;
  ifld_trap_t  cause_reg;
  logic [2:0]  ftt_reg;
  logic        done_reg;
  logic        is_dbl_reg;

  // latched kind bits: sb sh ub uh fp fsr flags
  wire k_sb  = kind_reg[0];
  wire k_sh  = kind_reg[1];
  wire k_ub  = kind_reg[2];
  wire k_uh  = kind_reg[3];
  wire k_fp  = kind_reg[4];
  wire k_fsr = kind_reg[5];
  wire k_dbl = state_reg == ST_MEM1;

  wire accept   = issue_valid & issue_ready & op_any;
  wire start_ok = accept & (trap_sel == TRAP_NONE);

  // next-state logic
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  begin
        if (start_ok) begin
          state_next = (op_fsr && float_operate_busy) ? ST_DRAIN : ST_MEM0;
        end
      end
      ST_DRAIN: begin
        if (!float_operate_busy) begin
          state_next = ST_MEM0;
        end
      end
      ST_MEM0:  begin
        if (mem_ack) begin
          state_next = is_dbl_reg ? ST_MEM1 : ST_DONE;
        end
      end
      ST_MEM1:  begin
        if (mem_ack) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  // memory side: request held until ack, lock spans both doubleword beats
  assign issue_ready = state_reg == ST_IDLE;
  assign mem_req     = (state_reg == ST_MEM0) | (state_reg == ST_MEM1);
  assign mem_lock    = mem_req & is_dbl_reg;
  assign mem_addr    = (state_reg == ST_MEM1) ? (addr_reg + 32'h0000_0004) : addr_reg;
  assign mem_space   = space_reg;

  // the odd half of a pair goes to rd|1; integer pair 0 even word is dropped
  wire [4:0] even_idx = {rd_reg[4:1], 1'b0};
  wire [4:0] odd_idx  = {rd_reg[4:1], 1'b1};
  wire       int_skip = ~k_fp & ~k_dbl & is_dbl_reg & (rd_reg[4:1] == 4'h0);
  wire [31:0] beat    = align_data(mem_rdata, addr_reg[1:0], k_sb, k_sh, k_ub, k_uh);

  // capture instruction at an accept that raises no trap
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_reg   <= ZERO_WORD;
      space_reg  <= 8'h00;
      rd_reg     <= 5'h00;
      kind_reg   <= 6'h00;
      is_dbl_reg <= 1'b0;
    end else if (start_ok) begin
      addr_reg   <= eff_addr;
      space_reg  <= space_sel;
      rd_reg     <= dest_reg_field;
      kind_reg   <= {op_fsr, op_fp, op_uh, op_ub, op_sh, op_sb};
      is_dbl_reg <= is_dbl;
    end
  end

  // state and writeback registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      data_reg   <= ZERO_WORD;
      wr_int_reg <= 1'b0;
      wr_fp_reg  <= 1'b0;
      wr_fsr_reg <= 1'b0;
      wr_idx_reg <= 5'h00;
    end else begin
      state_reg  <= state_next;
      wr_int_reg <= mem_req & mem_ack & ~k_fp & ~int_skip;
      wr_fp_reg  <= mem_req & mem_ack & k_fp & ~k_fsr;
      wr_fsr_reg <= mem_req & mem_ack & k_fsr;
      wr_idx_reg <= is_dbl_reg ? (k_dbl ? odd_idx : even_idx) : rd_reg;
      if (mem_req & mem_ack) begin
        data_reg <= beat;
      end
    end
  end

  // trap reporting, one cycle after the refused issue
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trap_reg  <= 1'b0;
      cause_reg <= TRAP_NONE;
      ftt_reg   <= 3'h0;
      done_reg  <= 1'b0;
    end else begin
      trap_reg  <= accept & (trap_sel != TRAP_NONE);
      cause_reg <= accept ? trap_sel : TRAP_NONE;
      ftt_reg   <= (accept & (trap_sel == TRAP_FPFLT)) ? FTT_BAD_REG : 3'h0;
      done_reg  <= (state_reg == ST_DONE) | (accept & (trap_sel != TRAP_NONE));
    end
  end

  assign int_wr_en       = wr_int_reg;
  assign fp_wr_en        = wr_fp_reg;
  assign fsr_wr_en       = wr_fsr_reg;  // no float branch interlock, codes left undefined
  assign int_wr_idx      = wr_idx_reg;
  assign fp_wr_idx       = wr_idx_reg;
  assign wr_data         = data_reg;
  assign trap_valid      = trap_reg;
  assign trap_cause      = cause_reg;
  assign float_trap_type = ftt_reg;
  assign done            = done_reg;

  // checks
  sequence fsr_issue_busy_s;
    accept && op_fsr && (trap_sel == TRAP_NONE) && float_operate_busy;
  endsequence

  priv_alt_trap_a: assert property (@(posedge core_clk) disable iff (rst)
    accept && op_alt && !supervisor_bit && !fp_off |=> trap_valid && trap_cause == TRAP_PRIV)
    else $error("alternate load in user state did not trap");
  imm_alt_trap_a: assert property (@(posedge core_clk) disable iff (rst)
    accept && op_alt && supervisor_bit && imm_sel |=> trap_cause == TRAP_ENC)
    else $error("alternate load with immediate did not trap");
  fp_off_trap_a: assert property (@(posedge core_clk) disable iff (rst)
    accept && op_fp && !fpu_enable_bit |=> trap_valid && trap_cause == TRAP_FPOFF)
    else $error("float load with fpu off did not trap");
  odd_fd_trap_a: assert property (@(posedge core_clk) disable iff (rst)
    accept && trap_sel == TRAP_FPFLT |=> float_trap_type == FTT_BAD_REG)
    else $error("bad float register code missing");
  align_trap_a: assert property (@(posedge core_clk) disable iff (rst)
    accept && (op_sb || op_ub) && !priv_bad && !enc_bad |=> !trap_valid)
    else $error("byte load raised a trap");
  fsr_drain_wait_a: assert property (@(posedge core_clk) disable iff (rst)
    fsr_issue_busy_s |=> !mem_req)
    else $error("state load issued while float work busy");
  dbl_second_addr_a: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == ST_MEM1 |-> mem_addr == $past(addr_reg) + 32'h0000_0004 && mem_lock)
    else $error("second doubleword beat address wrong");
  pair_zero_skip_a: assert property (@(posedge core_clk) disable iff (rst)
    int_wr_en |-> !(is_dbl_reg && int_wr_idx == 5'h00))
    else $error("register zero written by doubleword");
  sign_ext_a: assert property (@(posedge core_clk) disable iff (rst)
    mem_req && mem_ack && k_sb |=> wr_data[31:8] == {24{wr_data[7]}})
    else $error("signed byte not extended");

  // independent address sums, so the checks do not reuse the datapath adder
  wire [31:0] chk_sum_rr = src_one_value + src_two_value;
  wire [31:0] chk_sum_ri = src_one_value + {{19{instr[12]}}, instr[12:0]};

  // first and second beat of a pair as seen on the memory side
  sequence dbl_first_s;
    mem_req && mem_ack && (state_reg == ST_MEM0) && is_dbl_reg;
  endsequence
  sequence dbl_second_s;
    mem_req && mem_ack && (state_reg == ST_MEM1);
  endsequence

  // address and space of an accepted load
  addr_reg_sum_a: assert property (@(posedge core_clk) disable iff (rst)
    start_ok && !imm_sel |=> mem_addr == $past(chk_sum_rr))
    else $error("register plus register address wrong");
  addr_imm_sum_a: assert property (@(posedge core_clk) disable iff (rst)
    start_ok && imm_sel |=> mem_addr == $past(chk_sum_ri))
    else $error("register plus offset address wrong");
  alt_space_a: assert property (@(posedge core_clk) disable iff (rst)
    start_ok && op_alt |=> mem_space == $past(space_id_field))
    else $error("alternate space id not used");
  norm_space_a: assert property (@(posedge core_clk) disable iff (rst)
    start_ok && !op_alt |=> mem_space == ($past(supervisor_bit) ? ASI_SUPV_DATA : ASI_USER_DATA))
    else $error("normal data space wrong");

  // traps, raised before any access is made
  word_align_a: assert property (@(posedge core_clk) disable iff (rst)
    accept && op_w && !priv_bad && !enc_bad && (eff_addr[1:0] != 2'h0) |=> trap_cause == TRAP_ALIGN)
    else $error("misaligned word load did not trap");
  half_align_a: assert property (@(posedge core_clk) disable iff (rst)
    accept && (op_sh || op_uh) && !priv_bad && !enc_bad && eff_addr[0] |=> trap_cause == TRAP_ALIGN)
    else $error("misaligned halfword load did not trap");
  dbl_align_a: assert property (@(posedge core_clk) disable iff (rst)
    accept && op_d && !priv_bad && !enc_bad && (eff_addr[2:0] != 3'h0) |=> trap_cause == TRAP_ALIGN)
    else $error("misaligned doubleword load did not trap");
  fp_word_align_a: assert property (@(posedge core_clk) disable iff (rst)
    accept && (op_fs || op_fsr) && !fp_off && (eff_addr[1:0] != 2'h0) |=> trap_cause == TRAP_ALIGN)
    else $error("misaligned float word load did not trap");
  fp_dbl_align_a: assert property (@(posedge core_clk) disable iff (rst)
    accept && op_fd && !fp_off && !dest_reg_field[0] && (eff_addr[2:0] != 3'h0) |=> trap_cause == TRAP_ALIGN)
    else $error("misaligned float double load did not trap");
  odd_pair_enc_a: assert property (@(posedge core_clk) disable iff (rst)
    accept && op_d && !priv_bad && dest_reg_field[0] |=> trap_valid && trap_cause == TRAP_ENC)
    else $error("odd integer pair did not trap");
  no_fpu_trap_a: assert property (@(posedge core_clk) disable iff (rst)
    accept && op_fp && !fpu_present |=> trap_valid && trap_cause == TRAP_FPOFF)
    else $error("float load without fpu did not trap");
  trap_no_req_a: assert property (@(posedge core_clk) disable iff (rst)
    accept && (trap_sel != TRAP_NONE) |=> !mem_req && issue_ready)
    else $error("trapped load reached memory");
  trap_no_write_a: assert property (@(posedge core_clk) disable iff (rst)
    trap_valid |-> !int_wr_en && !fp_wr_en && !fsr_wr_en)
    else $error("trapped load wrote a register");

  // writeback of each beat
  unsigned_byte_a: assert property (@(posedge core_clk) disable iff (rst)
    mem_req && mem_ack && k_ub |=> wr_data[31:8] == 24'h00_0000)
    else $error("unsigned byte not zero filled");
  unsigned_half_a: assert property (@(posedge core_clk) disable iff (rst)
    mem_req && mem_ack && k_uh |=> wr_data[31:16] == 16'h0000)
    else $error("unsigned halfword not zero filled");
  signed_half_a: assert property (@(posedge core_clk) disable iff (rst)
    mem_req && mem_ack && k_sh |=> wr_data[31:16] == {16{wr_data[15]}})
    else $error("signed halfword not extended");
  int_byte_write_a: assert property (@(posedge core_clk) disable iff (rst)
    mem_req && mem_ack && k_sb |=> int_wr_en && !fp_wr_en)
    else $error("signed byte not written to integer file");
  word_write_a: assert property (@(posedge core_clk) disable iff (rst)
    mem_req && mem_ack && !k_fp && !is_dbl_reg |=> int_wr_en && int_wr_idx == $past(rd_reg))
    else $error("integer load wrote wrong register");
  pair_even_first_a: assert property (@(posedge core_clk) disable iff (rst)
    dbl_first_s ##0 (!k_fp && rd_reg[4:1] != 4'h0) |=> int_wr_en && !int_wr_idx[0])
    else $error("first pair word not in even register");
  pair_odd_second_a: assert property (@(posedge core_clk) disable iff (rst)
    dbl_second_s ##0 !k_fp |=> int_wr_en && int_wr_idx[0])
    else $error("second pair word not in odd register");
  pair_zero_even_a: assert property (@(posedge core_clk) disable iff (rst)
    dbl_first_s ##0 (!k_fp && rd_reg[4:1] == 4'h0) |=> !int_wr_en)
    else $error("pair zero first word was written");
  fp_even_first_a: assert property (@(posedge core_clk) disable iff (rst)
    dbl_first_s ##0 k_fp |=> fp_wr_en && !fp_wr_idx[0])
    else $error("first float pair word not in even register");
  fp_pair_odd_a: assert property (@(posedge core_clk) disable iff (rst)
    dbl_second_s ##0 k_fp |=> fp_wr_en && fp_wr_idx[0])
    else $error("second float pair word not in odd register");
  fp_single_write_a: assert property (@(posedge core_clk) disable iff (rst)
    mem_req && mem_ack && k_fp && !k_fsr && !is_dbl_reg |=> fp_wr_en && fp_wr_idx == $past(rd_reg))
    else $error("single float load wrote wrong register");
  fsr_write_a: assert property (@(posedge core_clk) disable iff (rst)
    mem_req && mem_ack && k_fsr |=> fsr_wr_en && !fp_wr_en && !int_wr_en)
    else $error("state load wrote wrong target");

  // locking and completion of a pair, state load drain
  pair_locked_a: assert property (@(posedge core_clk) disable iff (rst)
    dbl_first_s |=> mem_req && mem_lock)
    else $error("pair lost its lock between beats");
  done_after_pair_a: assert property (@(posedge core_clk) disable iff (rst)
    dbl_second_s |=> ##1 done)
    else $error("pair did not complete in time");
  drain_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == ST_DRAIN) && float_operate_busy |=> !mem_req)
    else $error("state load left drain while float work busy");
endmodule

// *** sim/ifld_mem_model.sv ***
// memory partner model answering load beats promptly or after a stall
`timescale 1ns/100ps
module ifld_mem_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [1:0] wait_reg;
  // one-cycle ack; data inverts off the ack so stale words never match
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      wait_reg <= 2'h0;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_req && !mem_ack && (!slow || wait_reg == 2'h3)) begin
      mem_ack <= 1'b1;
      wait_reg <= 2'h0;
      mem_rdata <= {mem_addr[31:2], 2'b00} ^ 32'h5A3C_96E1;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_reg <= (mem_req && !mem_ack) ? wait_reg + 2'h1 : wait_reg;
    end
  end
endmodule

// *** sim/tb_ifld_load_unit.sv ***
// self-checking bench for the load unit, random loads plus corner cases
`timescale 1ns/100ps
module tb_ifld_load_unit;
  import ifld_pkg::*;
  logic        core_clk, rst, issue_valid, supervisor_bit, fpu_enable_bit, fpu_present, float_operate_busy, slow;
  logic        issue_ready, mem_req, mem_lock, mem_ack, int_wr_en, fp_wr_en, fsr_wr_en, trap_valid, done;
  logic [31:0] instr, src_one_value, src_two_value, mem_addr, mem_rdata, wr_data;
  logic [7:0]  mem_space;
  logic [4:0]  int_wr_idx, fp_wr_idx;
  logic [2:0]  float_trap_type;
  ifld_trap_t  trap_cause;
  logic [5:0]  ops [15];
  int          fail_count, checks_done, cycles, seed;

  ifld_load_unit uut (.core_clk(core_clk), .rst(rst), .issue_valid(issue_valid), .instr(instr),
    .src_one_value(src_one_value), .src_two_value(src_two_value), .supervisor_bit(supervisor_bit),
    .fpu_enable_bit(fpu_enable_bit), .fpu_present(fpu_present), .float_operate_busy(float_operate_busy),
    .issue_ready(issue_ready), .mem_req(mem_req), .mem_lock(mem_lock), .mem_addr(mem_addr),
    .mem_space(mem_space), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .int_wr_en(int_wr_en),
    .int_wr_idx(int_wr_idx), .fp_wr_en(fp_wr_en), .fp_wr_idx(fp_wr_idx), .fsr_wr_en(fsr_wr_en),
    .wr_data(wr_data), .trap_valid(trap_valid), .trap_cause(trap_cause),
    .float_trap_type(float_trap_type), .done(done));
  ifld_mem_model mem (.core_clk(core_clk), .rst(rst), .slow(slow), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #2.5 core_clk = ~core_clk;
  // hang guard, well above 300 loads of at most some 60 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] mw(input logic [31:0] x);
    return {x[31:2], 2'b00} ^ 32'h5A3C_96E1;
  endfunction

  // big-endian lanes, extension by opcode
  function automatic logic [31:0] exp_val(input logic [5:0] op, input logic [31:0] w, input logic [1:0] lo);
    logic [7:0]  by;
    logic [15:0] hw;
    by = w[8 * (3 - lo) +: 8];
    hw = w[16 * (1 - lo[1]) +: 16];
    if (op[5]) return w;
    case (op[3:0])
      4'h9: return {{24{by[7]}}, by};
      4'hA: return {{16{hw[15]}}, hw};
      4'h1: return {24'h00_0000, by};
      4'h2: return {16'h0000, hw};
      default: return w;
    endcase
  endfunction

  // trap priority as chosen: fpu off, privilege, encoding, fpu fault, alignment
  function automatic logic [2:0] exp_trap(input logic [31:0] ins, ea);
    logic [5:0] op;
    logic [2:0] m;
    op = ins[24:19];
    m = (op[1:0] == 2'b11) ? 3'h7 : (op[5] || op[1:0] == 2'b00) ? 3'h3 : (op[1:0] == 2'b10) ? 3'h1 : 3'h0;
    if (op[5] && !(fpu_enable_bit && fpu_present)) return TRAP_FPOFF;
    if (op[4] && !supervisor_bit) return TRAP_PRIV;
    if ((op[4] && ins[13]) || (!op[5] && op[1:0] == 2'b11 && ins[25])) return TRAP_ENC;
    if (op == OP_FLDD && ins[25]) return TRAP_FPFLT;
    if ((ea[2:0] & m) != 3'h0) return TRAP_ALIGN;
    return TRAP_NONE;
  endfunction

  // issue one load, then watch beats, writes and traps until done
  task automatic run(input logic [31:0] ins, a, b, input int hold);
    logic [31:0] ea;
    logic [5:0]  op;
    logic [4:0]  rd;
    logic [2:0]  tc;
    logic        dbl, skip, fin, tseen;
    int          nb, nw;
    @(posedge core_clk);
    issue_valid <= 1'b1;
    instr <= ins;
    src_one_value <= a;
    src_two_value <= b;
    float_operate_busy <= (hold > 0);
    @(posedge core_clk);
    issue_valid <= 1'b0;
    op = ins[24:19];
    rd = ins[29:25];
    ea = a + (ins[13] ? {{19{ins[12]}}, ins[12:0]} : b);
    tc = exp_trap(ins, ea);
    dbl = (op[1:0] == 2'b11);
    skip = dbl && !op[5] && rd == 5'h00;
    {nb, nw, fin, tseen} = '0;
    for (int k = 0; k < 60 && !fin; k++) begin
      if (k > 0) @(posedge core_clk);
      if (k == hold) float_operate_busy <= 1'b0;
      #1;
      if (k == 0) chk("issue_ready", {31'h0, tc != 3'h0}, {31'h0, issue_ready});
      if (float_operate_busy === 1'b1) chk("mem_req", 32'h0, {31'h0, mem_req});
      if (mem_req === 1'b1 && mem_ack === 1'b1) begin
        chk("mem_addr", ea + 32'(4 * nb), mem_addr);
        chk("mem_space", {24'h0, op[4] ? ins[12:5] : supervisor_bit ? ASI_SUPV_DATA : ASI_USER_DATA},
            {24'h0, mem_space});
        if (dbl) chk("mem_lock", 32'h1, {31'h0, mem_lock});
        nb++;
      end
      if ((int_wr_en | fp_wr_en | fsr_wr_en) === 1'b1) begin
        chk("write kind", {29'h0, !op[5], op == OP_FLDS || op == OP_FLDD, op == OP_FLDSR},
            {29'h0, int_wr_en, fp_wr_en, fsr_wr_en});
        if (op != OP_FLDSR) chk("write index", {27'h0, dbl ? {rd[4:1], 1'(nw + skip)} : rd},
            {27'h0, op[5] ? fp_wr_idx : int_wr_idx});
        chk("wr_data", exp_val(op, mw(ea + 32'(4 * (nw + skip))), ea[1:0]), wr_data);
        nw++;
      end
      if (trap_valid === 1'b1) begin
        tseen = 1'b1;
        chk("trap_cause", {29'h0, tc}, {29'h0, trap_cause});
        if (tc == TRAP_FPFLT) chk("float_trap_type", {29'h0, FTT_BAD_REG}, {29'h0, float_trap_type});
      end
      fin = (done === 1'b1);
    end
    chk("done", 32'h1, {31'h0, fin});
    chk("trap seen", {31'h0, tc != 3'h0}, {31'h0, tseen});
    chk("beats", (tc != 3'h0) ? 0 : dbl ? 2 : 1, nb);
    chk("writes", (tc != 3'h0) ? 0 : dbl ? 2 - skip : 1, nw);
  endtask

  initial begin
    logic [31:0] r, a, b;
    {core_clk, rst, issue_valid, float_operate_busy, slow} = 5'b01000;
    {supervisor_bit, fpu_enable_bit, fpu_present} = 3'b111;
    {instr, src_one_value, src_two_value} = '0;
    {fail_count, checks_done, cycles} = '0;
    seed = 52;
    ops = '{OP_LDSB, OP_LDSH, OP_LDUB, OP_LDUH, OP_LDW, OP_LDD, OP_LDSBA, OP_LDSHA, OP_LDUBA, OP_LDUHA,
            OP_LDWA, OP_LDDA, OP_FLDS, OP_FLDD, OP_FLDSR};
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    // corner cases: pair 0, odd pairs, float state wait, immediate on alternate
    run({2'b11, 5'h00, OP_LDD, 5'h01, 1'b1, 13'h1FF8}, 32'h0000_1000, 32'h0, 0);
    run({2'b11, 5'h03, OP_LDD, 19'h0}, 32'h0000_2000, 32'h8, 0);
    run({2'b11, 5'h05, OP_FLDD, 19'h0}, 32'h0000_2000, 32'h0, 0);
    run({2'b11, 5'h00, OP_FLDSR, 19'h0}, 32'h0000_2004, 32'h0, 4);
    run({2'b11, 5'h04, OP_LDWA, 5'h00, 1'b1, 13'h0}, 32'h0000_0040, 32'h0, 0);
    // random mix over every load opcode, state bits and memory speed
    repeat (300) begin
      @(posedge core_clk);
      supervisor_bit <= ($random(seed) % 4) != 0;
      fpu_enable_bit <= ($random(seed) % 6) != 0;
      fpu_present <= ($random(seed) % 6) != 0;
      slow <= 1'($random(seed));
      r = $random(seed);
      a = $random(seed);
      b = $random(seed);
      if (r[30]) {a[2:0], b[2:0], r[2:0]} = 9'h000;
      r[31:30] = 2'b11;
      r[24:19] = ops[$unsigned($random(seed)) % 15];
      if (!r[28]) r[25] = 1'b0;
      if (r[29:25] == 5'h00) r[27] = 1'b1;
      if (r[23] && r[11]) r[13] = 1'b0;
      run(r, a, b, (r[24:19] == OP_FLDSR) ? 2 : 0);
    end
    end_of_test();
  end
endmodule
